//--- src/pas_pkg.sv
// Package for the pipe A second-level event status and enable register
package pas_pkg;

    // Register geometry
    localparam int          PAS_DW          = 32;
    localparam logic [31:0] PAS_RESET_VAL   = 32'h0000_0000;
    // Writable enable bits: 30 and 27..16
    localparam logic [31:0] PAS_ENA_MASK    = 32'h4fff_0000;
    // One-to-clear status bits: 15, 14 and 11..0
    localparam logic [31:0] PAS_STAT_MASK   = 32'h0000_cfff;

    // Status bit positions
    localparam int PAS_ST_SPR_B_FLIP  = 15;
    localparam int PAS_ST_SPR_A_FLIP  = 14;
    localparam int PAS_ST_GMB         = 11;
    localparam int PAS_ST_PLN_A_FLIP  = 10;
    localparam int PAS_ST_VSYNC       = 9;
    localparam int PAS_ST_LINE_CMP    = 8;
    localparam int PAS_ST_BLPS        = 7;
    localparam int PAS_ST_PSR         = 6;
    localparam int PAS_ST_ODD_FIELD   = 5;
    localparam int PAS_ST_EVEN_FIELD  = 4;
    localparam int PAS_ST_PERF_MON    = 3;
    localparam int PAS_ST_VBL_START   = 2;
    localparam int PAS_ST_FRAME_START = 1;
    localparam int PAS_ST_HBLANK      = 0;

    // Enable bit positions
    localparam int PAS_EN_SPR_B_FLIP  = 30;
    localparam int PAS_EN_GMB         = 27;
    localparam int PAS_EN_PLN_A_FLIP  = 26;
    localparam int PAS_EN_VSYNC       = 25;
    localparam int PAS_EN_LINE_CMP    = 24;
    localparam int PAS_EN_BLPS        = 23;
    localparam int PAS_EN_SPR_A_FLIP  = 22;
    localparam int PAS_EN_ODD_FIELD   = 21;
    localparam int PAS_EN_EVEN_FIELD  = 20;
    localparam int PAS_EN_PERF_MON    = 19;
    localparam int PAS_EN_VBL_START   = 18;
    localparam int PAS_EN_FRAME_START = 17;
    localparam int PAS_EN_HBLANK      = 16;

    // One-cycle event pulses from the pipe's event generators
    typedef struct packed {
        logic sprite_b_flip;
        logic sprite_a_flip;
        logic graphics_management_bus;
        logic plane_a_flip;
        logic vsync;
        logic line_cmp;
        logic backlight_power_saving;
        logic panel_self_refresh;
        logic odd_field;
        logic even_field;
        logic perf_mon;
        logic vblank_start;
        logic frame_start;
        logic hblank;
    } pas_evt_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } pas_req_t;

endpackage : pas_pkg

//--- src/pas_sticky.sv
// Bank of sticky one-to-clear flags
`timescale 1ns/1ps
module pas_sticky #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Set and clear vectors
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    // Flag state
    output logic      [W-1:0] flags_ff
);

    // Set beats clear so an event landing on a clear is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (flags_ff & ~clr_in) | set_in;
        end
    end

endmodule : pas_sticky

//--- src/pas_status.sv
// Pipe A second-level event status and enable register with summary output
`timescale 1ns/1ps
module pas_status
    import pas_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Register access port
    input  wire pas_pkg::pas_req_t reg_req,
    output logic [31:0]           reg_rdata_ff,
    output logic                  reg_rvalid_ff,
    // Event pulses from the pipe
    input  wire pas_pkg::pas_evt_t evt,
    // Qualifiers from neighbouring registers
    input  wire logic             psr_irq_en,
    input  wire logic             field0_only_mode,
    // First-level summary
    output logic                  irq_summary_ff
);
    import pas_pkg::*;

    logic [31:0] ena_ff;
    logic [31:0] stat_ff;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] gated;
    logic        psr_fwd;
    logic        nxt_summary;
    logic [31:0] rd_val;

    // Enable bits: plain storage, only documented enable positions kept
    // reserved positions masked
    always_ff @(posedge mclk) begin
        if (rst) begin
            ena_ff <= PAS_RESET_VAL;
        end else if (reg_req.wr) begin
            ena_ff <= reg_req.wdata & PAS_ENA_MASK;
        end
    end

    // Map event pulses onto status positions
    always_comb begin
        set_vec = '0;
        set_vec[PAS_ST_SPR_B_FLIP]  = evt.sprite_b_flip;
        set_vec[PAS_ST_SPR_A_FLIP]  = evt.sprite_a_flip;
        set_vec[PAS_ST_GMB]         = evt.graphics_management_bus;
        set_vec[PAS_ST_PLN_A_FLIP]  = evt.plane_a_flip;
        // vertical sync, one per field or frame as the generator pulses
        set_vec[PAS_ST_VSYNC]       = evt.vsync;
        set_vec[PAS_ST_LINE_CMP]    = evt.line_cmp;
        // backlight power-saving event only; panel self-refresh has its own bit
        set_vec[PAS_ST_BLPS]        = evt.backlight_power_saving;
        set_vec[PAS_ST_PSR]         = evt.panel_self_refresh;
        // odd field, suppressed in field-0-only mode
        set_vec[PAS_ST_ODD_FIELD]   = evt.odd_field & ~field0_only_mode;
        set_vec[PAS_ST_EVEN_FIELD]  = evt.even_field & ~field0_only_mode;
        set_vec[PAS_ST_PERF_MON]    = evt.perf_mon;
        set_vec[PAS_ST_VBL_START]   = evt.vblank_start;
        set_vec[PAS_ST_FRAME_START] = evt.frame_start;
        set_vec[PAS_ST_HBLANK]      = evt.hblank;
    end

    // Only ones written into status positions clear
    // zero bits leave status alone
    assign clr_vec = reg_req.wr ? (reg_req.wdata & PAS_STAT_MASK) : 32'h0000_0000;

    // Sticky status bank
    pas_sticky #(
        .W (PAS_DW)
    ) u_sticky (
        .mclk     (mclk),
        .rst      (rst),
        .set_in   (set_vec & PAS_STAT_MASK),
        .clr_in   (clr_vec),
        .flags_ff (stat_ff)
    );

    // Self-refresh bit has no enable here, only the neighbouring one
    // gated by external enable
    assign psr_fwd = stat_ff[PAS_ST_PSR] & psr_irq_en;

    // Pair each status with its enable
    always_comb begin
        gated = '0;
        gated[0]  = stat_ff[PAS_ST_GMB]         & ena_ff[PAS_EN_GMB];
        gated[1]  = stat_ff[PAS_ST_PLN_A_FLIP]  & ena_ff[PAS_EN_PLN_A_FLIP];
        gated[2]  = stat_ff[PAS_ST_VSYNC]       & ena_ff[PAS_EN_VSYNC];
        gated[3]  = stat_ff[PAS_ST_LINE_CMP]    & ena_ff[PAS_EN_LINE_CMP];
        gated[4]  = stat_ff[PAS_ST_BLPS]        & ena_ff[PAS_EN_BLPS];
        gated[5]  = stat_ff[PAS_ST_SPR_A_FLIP]  & ena_ff[PAS_EN_SPR_A_FLIP];
        // Field enables are only meaningful when software follows interlace use
        // field event gating
        gated[6]  = stat_ff[PAS_ST_ODD_FIELD]   & ena_ff[PAS_EN_ODD_FIELD];
        gated[7]  = stat_ff[PAS_ST_EVEN_FIELD]  & ena_ff[PAS_EN_EVEN_FIELD];
        gated[8]  = stat_ff[PAS_ST_PERF_MON]    & ena_ff[PAS_EN_PERF_MON];
        gated[9]  = stat_ff[PAS_ST_VBL_START]   & ena_ff[PAS_EN_VBL_START];
        gated[10] = stat_ff[PAS_ST_FRAME_START] & ena_ff[PAS_EN_FRAME_START];
        gated[11] = stat_ff[PAS_ST_HBLANK]      & ena_ff[PAS_EN_HBLANK];
        gated[12] = stat_ff[PAS_ST_SPR_B_FLIP]  & ena_ff[PAS_EN_SPR_B_FLIP];
        gated[13] = psr_fwd;
    end

    // Summary reduction
    // OR of gated sources
    assign nxt_summary = |gated;

    // Registered so the first level sees a glitch-free level
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_summary_ff <= 1'b0;
        end else begin
            irq_summary_ff <= nxt_summary;
        end
    end

    // Read value
    // reserved and unused bits read zero
    assign rd_val = (ena_ff & PAS_ENA_MASK) | (stat_ff & PAS_STAT_MASK);

    // Read data captured one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_ff  <= 32'h0000_0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata_ff <= rd_val;
            end
        end
    end

    // Assertions
    // summary follows gates
    a_summary_or: assert property (@(posedge mclk) disable iff (rst)
        ##1 irq_summary_ff == $past(|gated))
        else $error("summary does not follow gated status");

    a_gmb_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_GMB] && ena_ff[PAS_EN_GMB]) |=> irq_summary_ff)
        else $error("enabled bus status did not raise summary");

    a_gmb_mask: assert property (@(posedge mclk) disable iff (rst)
        (!ena_ff[PAS_EN_GMB] && !(|gated[13:1])) |=> !irq_summary_ff)
        else $error("masked bus status raised summary");

    a_plane_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_PLN_A_FLIP] && ena_ff[PAS_EN_PLN_A_FLIP]) |=> irq_summary_ff)
        else $error("enabled plane flip status did not raise summary");

    a_vsync_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_VSYNC] && ena_ff[PAS_EN_VSYNC]) |=> irq_summary_ff)
        else $error("enabled vsync status did not raise summary");

    a_line_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_LINE_CMP] && ena_ff[PAS_EN_LINE_CMP]) |=> irq_summary_ff)
        else $error("enabled line compare status did not raise summary");

    a_blps_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_BLPS] && ena_ff[PAS_EN_BLPS]) |=> irq_summary_ff)
        else $error("enabled power-saving status did not raise summary");

    a_spra_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_SPR_A_FLIP] && ena_ff[PAS_EN_SPR_A_FLIP]) |=> irq_summary_ff)
        else $error("enabled sprite A status did not raise summary");

    a_perf_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_PERF_MON] && ena_ff[PAS_EN_PERF_MON]) |=> irq_summary_ff)
        else $error("enabled performance status did not raise summary");

    a_vblank_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_VBL_START] && ena_ff[PAS_EN_VBL_START]) |=> irq_summary_ff)
        else $error("enabled blank start status did not raise summary");

    a_frame_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_FRAME_START] && ena_ff[PAS_EN_FRAME_START]) |=> irq_summary_ff)
        else $error("enabled frame start status did not raise summary");

    a_hblank_gate: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_HBLANK] && ena_ff[PAS_EN_HBLANK]) |=> irq_summary_ff)
        else $error("enabled horizontal blank status did not raise summary");

    a_sprb_set: assert property (@(posedge mclk) disable iff (rst)
        evt.sprite_b_flip |=> stat_ff[PAS_ST_SPR_B_FLIP])
        else $error("sprite B flip event not latched");

    a_sticky_hold: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_SPR_A_FLIP] && !reg_req.wr) |=> stat_ff[PAS_ST_SPR_A_FLIP])
        else $error("sticky bit dropped without clear");

    a_set_wins: assert property (@(posedge mclk) disable iff (rst)
        (evt.graphics_management_bus && reg_req.wr && reg_req.wdata[PAS_ST_GMB])
        |=> stat_ff[PAS_ST_GMB])
        else $error("event lost under simultaneous clear");

    a_plane_set: assert property (@(posedge mclk) disable iff (rst)
        evt.plane_a_flip |=> stat_ff[PAS_ST_PLN_A_FLIP])
        else $error("plane flip event not latched");

    a_vsync_set: assert property (@(posedge mclk) disable iff (rst)
        evt.vsync |=> stat_ff[PAS_ST_VSYNC])
        else $error("vsync event not latched");

    a_clear_one: assert property (@(posedge mclk) disable iff (rst)
        (reg_req.wr && reg_req.wdata[PAS_ST_LINE_CMP] && !evt.line_cmp)
        |=> !stat_ff[PAS_ST_LINE_CMP])
        else $error("write one did not clear line compare");

    a_blps_set: assert property (@(posedge mclk) disable iff (rst)
        evt.backlight_power_saving |=> stat_ff[PAS_ST_BLPS])
        else $error("power-saving event not latched");

    a_psr_gate: assert property (@(posedge mclk) disable iff (rst)
        (!psr_irq_en && ena_ff == 32'h0000_0000) |=> !irq_summary_ff)
        else $error("self-refresh forwarded without its enable");

    a_psr_fwd: assert property (@(posedge mclk) disable iff (rst)
        (stat_ff[PAS_ST_PSR] && psr_irq_en) |=> irq_summary_ff)
        else $error("enabled self-refresh status did not raise summary");

    a_odd_block: assert property (@(posedge mclk) disable iff (rst)
        (!stat_ff[PAS_ST_ODD_FIELD] && field0_only_mode) |=> !stat_ff[PAS_ST_ODD_FIELD])
        else $error("odd field set in field-0-only mode");

    a_zero_keeps: assert property (@(posedge mclk) disable iff (rst)
        (reg_req.wr && (stat_ff[PAS_ST_PLN_A_FLIP] && !reg_req.wdata[PAS_ST_PLN_A_FLIP]))
        |=> stat_ff[PAS_ST_PLN_A_FLIP])
        else $error("zero write disturbed status");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
        reg_rvalid_ff |-> (reg_rdata_ff & 32'hb000_3000) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_read_latency: assert property (@(posedge mclk) disable iff (rst)
        reg_req.rd |=> reg_rvalid_ff && reg_rdata_ff == $past(rd_val))
        else $error("read data not returned next cycle");

endmodule : pas_status

//--- verif/tb.sv
// Self-checking bench for the pipe A event status and enable register
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
    import pas_pkg::*;

    // Event index to status bit and enable bit; -1 means no local enable
    localparam int ST_POS [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 14, 15};
    localparam int EN_POS [14] = '{16, 17, 18, 19, 20, 21, -1, 23, 24, 25, 26, 27, 22, 30};

    logic        mclk;
    logic        rst;
    pas_req_t    reg_req;
    logic [31:0] reg_rdata_ff;
    logic        reg_rvalid_ff;
    pas_evt_t    evt;
    logic        psr_irq_en;
    logic        field0_only_mode;
    logic        irq_summary_ff;
    int          failures;
    int          checks;
    logic [31:0] q;
    logic [31:0] st;
    logic [31:0] en;

    pas_status i_pas_status (
        .mclk             (mclk),
        .rst              (rst),
        .reg_req          (reg_req),
        .reg_rdata_ff     (reg_rdata_ff),
        .reg_rvalid_ff    (reg_rvalid_ff),
        .evt              (evt),
        .psr_irq_en       (psr_irq_en),
        .field0_only_mode (field0_only_mode),
        .irq_summary_ff   (irq_summary_ff)
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task tally_and_finish;
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // One-cycle write strobe
    task wr(input logic [31:0] d);
        @(posedge mclk);
        reg_req.wr    <= 1'b1;
        reg_req.wdata <= d;
        @(posedge mclk);
        reg_req.wr    <= 1'b0;
    endtask : wr

    // Read strobe; data comes one cycle after it is taken
    task rd(output logic [31:0] d);
        @(posedge mclk);
        reg_req.rd <= 1'b1;
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        `CHK(reg_rvalid_ff, 1'b1)
        d = reg_rdata_ff;
    endtask : rd

    // One-cycle event pulse on struct bit i
    task pulse(input int i);
        @(posedge mclk);
        evt[i] <= 1'b1;
        @(posedge mclk);
        evt    <= '0;
    endtask : pulse

    // Summary is registered, so give it two edges to follow
    task settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle

    // Hang guard, 8000 cycles against the few hundred the tests need
    initial begin
        #200000;
        failures++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        reg_req = '0;
        evt = '0;
        psr_irq_en = 1'b0;
        field0_only_mode = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(q);
        `CHK(q, PAS_RESET_VAL)
        // Reserved bits stay zero, status ones only clear
        wr(32'hffff_ffff);
        rd(q);
        `CHK(q, PAS_ENA_MASK)
        wr(32'h0000_0000);
        // Field events are dropped in field-0-only mode
        field0_only_mode <= 1'b1;
        pulse(5);
        pulse(4);
        field0_only_mode <= 1'b0;
        rd(q);
        `CHK(q, 32'h0000_0000)
        // Every source: set while masked, then enable, then clear
        // field enables set only while field events flow
        for (int i = 0; i < 14; i++) begin
            st = 32'h1 << ST_POS[i];
            en = (EN_POS[i] < 0) ? 32'h0 : (32'h1 << EN_POS[i]);
            pulse(i);
            settle;
            `CHK(irq_summary_ff, 1'b0)
            rd(q);
            `CHK(q, st)
            wr(en);
            psr_irq_en <= (EN_POS[i] < 0);
            settle;
            `CHK(irq_summary_ff, 1'b1)
            rd(q);
            `CHK(q, en | st)
            wr(en | st);
            settle;
            `CHK(irq_summary_ff, 1'b0)
            rd(q);
            `CHK(q, en)
            wr(32'h0000_0000);
            psr_irq_en <= 1'b0;
        end
        // Event and write-one clear in one cycle: the event is kept
        pulse(11);
        @(posedge mclk);
        evt.graphics_management_bus <= 1'b1;
        reg_req.wr                  <= 1'b1;
        reg_req.wdata               <= 32'h0000_0800;
        @(posedge mclk);
        evt        <= '0;
        reg_req.wr <= 1'b0;
        rd(q);
        `CHK(q, 32'h0000_0800)
        wr(32'h0000_0800);
        rd(q);
        `CHK(q, 32'h0000_0000)
        // Reset in mid-run wipes enables and status
        wr(32'h0200_0000);
        pulse(9);
        settle;
        `CHK(irq_summary_ff, 1'b1)
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK(irq_summary_ff, 1'b0)
        rd(q);
        `CHK(q, PAS_RESET_VAL)
        tally_and_finish;
    end
endmodule : tb
